// ===== hw/gtmr_pkg.sv
// Package holding the register map, field layout, modes and shared helpers of the timer.
package gtmr_pkg;

  // Register byte offsets on the 32-bit bus
  localparam logic [7:0] GTMR_OFS_CTRL = 8'h00;
  localparam logic [7:0] GTMR_OFS_COUNT = 8'h04;
  localparam logic [7:0] GTMR_OFS_PERIOD = 8'h08;
  localparam logic [7:0] GTMR_OFS_STATUS = 8'h0C;
  localparam logic [7:0] GTMR_OFS_MASK = 8'h10;

  // Control register field positions
  localparam int unsigned GTMR_CTRL_RUN_BIT = 15;
  localparam int unsigned GTMR_CTRL_IDLE_BIT = 13;
  localparam int unsigned GTMR_CTRL_GATE_BIT = 6;
  localparam int unsigned GTMR_CTRL_PS_LSB = 4;
  localparam int unsigned GTMR_CTRL_SYNC_BIT = 2;
  localparam int unsigned GTMR_CTRL_SRC_BIT = 1;

  // Status and mask field positions
  localparam int unsigned GTMR_ST_MATCH_BIT = 0;
  localparam int unsigned GTMR_ST_GATE_BIT = 1;

  // Values after reset
  localparam logic [15:0] GTMR_COUNT_RST = 16'h0000;
  localparam logic [15:0] GTMR_PERIOD_RST = 16'hFFFF;
  localparam logic [1:0] GTMR_STATUS_RST = 2'h0;
  localparam logic [1:0] GTMR_MASK_RST = 2'h0;

  // Clock rate and instruction clock divide
  localparam int unsigned GTMR_CLK_MHZ = 100;
  localparam int unsigned GTMR_INSTR_DIV = 2;

  // Operating modes
  typedef enum logic [1:0] {
    GTMR_MODE_TIMER,
    GTMR_MODE_GATED,
    GTMR_MODE_SYNC_CNT,
    GTMR_MODE_ASYNC_CNT
  } gtmr_mode_e;

  // Control register contents
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate;
    logic [1:0] ps;
    logic sync;
    logic src;
  } gtmr_ctrl_s;

  localparam gtmr_ctrl_s GTMR_CTRL_RST = '{default: 1'b0};

  // Bus request carrier
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } gtmr_bus_req_s;

  // Mode from the source, gate and sync bits
  function automatic gtmr_mode_e gtmr_decode(input gtmr_ctrl_s c);
    if (!c.src)
      return c.gate ? GTMR_MODE_GATED : GTMR_MODE_TIMER;
    return c.sync ? GTMR_MODE_SYNC_CNT : GTMR_MODE_ASYNC_CNT;
  endfunction

  // Terminal prescaler count for a select code
  function automatic logic [7:0] gtmr_ps_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: return 8'h00;
      2'h1: return 8'h07;
      2'h2: return 8'h3F;
      2'h3: return 8'hFF;
    endcase
  endfunction

endpackage

// ===== hw/gtmr_prescaler.sv
// Input clock prescaler: one tick out per 1, 8, 64 or 256 input pulses.
`timescale 1ns/1ps

module gtmr_prescaler
  import gtmr_pkg::*;
#(
  parameter int unsigned PS_W = 8
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Control
  input wire logic clear_i,
  input wire logic [1:0] sel_i,
  // Pulses
  input wire logic pulse_i,
  output logic tick_o
);

  // The terminal count of a 256 divide needs eight bits
  if (PS_W < 8)
    $error("PS_W must hold a divide of 256");

  typedef struct packed {
    logic [PS_W-1:0] cnt;
  } gtmr_ps_state_s;

  gtmr_ps_state_s s_reg;
  gtmr_ps_state_s s_next;
  logic [PS_W-1:0] lim;

  // Terminal count widened to the counter
  assign lim = PS_W'(gtmr_ps_limit(sel_i));
  assign tick_o = pulse_i && !clear_i && (s_reg.cnt == lim);

  // Counter wraps at the terminal count, restarts on clear
  always_comb
  begin
    s_next = s_reg;
    if (clear_i)
      s_next.cnt = '0;
    else if (pulse_i)
      s_next.cnt = (s_reg.cnt == lim) ? '0 : s_reg.cnt + PS_W'(1);
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_PS_DIV: assert property (tick_o |=> s_reg.cnt == '0)
    else $error("prescaler did not wrap after a tick");
  AST_PS_NO_EARLY: assert property ((pulse_i && !clear_i && s_reg.cnt != lim) |-> !tick_o)
    else $error("prescaler ticked before its terminal count");

endmodule

// ===== hw/gtmr_timer.sv
// Sixteen-bit timer/counter with four modes, Avalon-MM registers and an interrupt.
`timescale 1ns/1ps

module gtmr_timer
  import gtmr_pkg::*;
#(
  parameter int unsigned INSTR_DIV = GTMR_INSTR_DIV
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pins and chip state
  input wire logic external_count_input_i,
  input wire logic gate_input_i,
  input wire logic idle_i,
  // Interrupt
  output logic irq_o
);

  // The instruction divider is eight bits wide, so larger divides cannot be served
  if (INSTR_DIV < 1 || INSTR_DIV > 256)
    $error("INSTR_DIV must lie in 1..256");

  // Whole state of the block
  typedef struct packed {
    gtmr_ctrl_s ctrl;
    logic [15:0] count;
    logic [15:0] period;
    logic [1:0] status;
    logic [1:0] mask;
    logic [2:0] pin_sync;
    logic [2:0] gate_sync;
    logic [7:0] fcy_cnt;
    logic fcy_en;
    logic ps_toggle;
    logic [2:0] tog_sync;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
  } gtmr_state_s;

  localparam logic [7:0] FCY_LAST = 8'(INSTR_DIV - 1);

  gtmr_state_s s_reg;
  gtmr_state_s s_next;
  gtmr_bus_req_s req;
  gtmr_mode_e mode;
  logic active;
  logic pin_rise;
  logic gate_level;
  logic gate_fall;
  logic ps_in;
  logic ps_clear;
  logic ps_tick;
  logic sync_tick;
  logic cnt_tick;
  logic wr_accept;
  logic wr_ctrl;
  logic wr_count_try;
  logic wr_blocked;
  logic match;
  logic [1:0] st_set;
  logic [1:0] st_clr;

  // Bus carrier
  assign req = '{read: avs_read_i, write: avs_write_i, addr: avs_address_i,
                 wdata: avs_writedata_i};

  // Register read multiplexer
  function automatic logic [31:0] read_mux(input logic [7:0] a, input gtmr_state_s s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      GTMR_OFS_CTRL:
      begin
        d[GTMR_CTRL_RUN_BIT] = s.ctrl.run;
        d[GTMR_CTRL_IDLE_BIT] = s.ctrl.idle_stop;
        d[GTMR_CTRL_GATE_BIT] = s.ctrl.gate;
        d[GTMR_CTRL_PS_LSB +: 2] = s.ctrl.ps;
        d[GTMR_CTRL_SYNC_BIT] = s.ctrl.sync;
        d[GTMR_CTRL_SRC_BIT] = s.ctrl.src;
      end
      GTMR_OFS_COUNT: d[15:0] = s.count;
      GTMR_OFS_PERIOD: d[15:0] = s.period;
      GTMR_OFS_STATUS: d[1:0] = s.status;
      GTMR_OFS_MASK: d[1:0] = s.mask;
      default: d = 32'h0000_0000; // Unmapped addresses read zero
    endcase
    return d;
  endfunction

  // Mode, source selection and gating
  assign mode = gtmr_decode(s_reg.ctrl);
  assign active = s_reg.ctrl.run && !(idle_i && s_reg.ctrl.idle_stop);
  assign pin_rise = s_reg.pin_sync[1] && !s_reg.pin_sync[2];
  assign gate_level = s_reg.gate_sync[1];
  assign gate_fall = !s_reg.gate_sync[1] && s_reg.gate_sync[2];

  // Prescaler input by mode
  always_comb
  begin
    ps_in = 1'b0;
    if (active)
    begin
      unique case (mode)
        GTMR_MODE_TIMER: ps_in = s_reg.fcy_en;
        GTMR_MODE_GATED: ps_in = s_reg.fcy_en && gate_level;
        GTMR_MODE_SYNC_CNT: ps_in = pin_rise;
        GTMR_MODE_ASYNC_CNT: ps_in = pin_rise;
      endcase
    end
  end

  // Writes are taken at the edge where waitrequest is seen low
  assign wr_accept = req.write && !s_reg.waitreq;
  assign wr_ctrl = wr_accept && (req.addr == GTMR_OFS_CTRL);
  assign wr_count_try = wr_accept && (req.addr == GTMR_OFS_COUNT);
  assign wr_blocked = s_reg.ctrl.run && s_reg.ctrl.src && s_reg.ctrl.sync;

  // Restarting the divider on any control change keeps old phase out of a new setting
  assign ps_clear = !s_reg.ctrl.run || wr_ctrl;

  gtmr_prescaler #(
    .PS_W(8)
  ) u_prescaler (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(ps_clear),
    .sel_i(s_reg.ctrl.ps),
    .pulse_i(ps_in),
    .tick_o(ps_tick)
  );

  // Aligned prescaler tick: a toggle carried through two flops
  assign sync_tick = s_reg.tog_sync[2] ^ s_reg.tog_sync[1];

  // Async mode takes the prescaler output as is; sync mode waits for the aligned copy
  assign cnt_tick = active && ((mode == GTMR_MODE_SYNC_CNT) ? sync_tick : ps_tick);
  assign match = cnt_tick && (s_reg.count == s_reg.period);

  // Status events and write-one-to-clear
  // Bit 1 marks the close of a gated interval, so software can time a pulse width
  assign st_set = {active && (mode == GTMR_MODE_GATED) && gate_fall, match};
  assign st_clr = (wr_accept && req.addr == GTMR_OFS_STATUS) ? req.wdata[1:0] : 2'h0;

  // Next state
  always_comb
  begin
    s_next = s_reg;
    // Pins pass two flops before any logic looks at them
    s_next.pin_sync = {s_reg.pin_sync[1:0], external_count_input_i};
    s_next.gate_sync = {s_reg.gate_sync[1:0], gate_input_i};
    // Instruction clock enable from the divider
    s_next.fcy_en = (s_reg.fcy_cnt == FCY_LAST);
    s_next.fcy_cnt = s_next.fcy_en ? 8'h00 : s_reg.fcy_cnt + 8'h01;
    // Event toggle for the aligned path
    if (ps_tick && mode == GTMR_MODE_SYNC_CNT)
      s_next.ps_toggle = !s_reg.ps_toggle;
    s_next.tog_sync = {s_reg.tog_sync[1:0], s_reg.ps_toggle};
    // Counting and period match
    if (match)
      s_next.count = GTMR_COUNT_RST;
    else if (cnt_tick)
      s_next.count = s_reg.count + 16'h0001;
    // Register writes; a count write wins over a tick unless blocked
    if (wr_ctrl)
    begin
      s_next.ctrl.run = req.wdata[GTMR_CTRL_RUN_BIT];
      s_next.ctrl.idle_stop = req.wdata[GTMR_CTRL_IDLE_BIT];
      s_next.ctrl.gate = req.wdata[GTMR_CTRL_GATE_BIT];
      s_next.ctrl.ps = req.wdata[GTMR_CTRL_PS_LSB +: 2];
      s_next.ctrl.sync = req.wdata[GTMR_CTRL_SYNC_BIT];
      s_next.ctrl.src = req.wdata[GTMR_CTRL_SRC_BIT];
    end
    if (wr_count_try && !wr_blocked)
      s_next.count = req.wdata[15:0];
    if (wr_accept && req.addr == GTMR_OFS_PERIOD)
      s_next.period = req.wdata[15:0];
    if (wr_accept && req.addr == GTMR_OFS_MASK)
      s_next.mask = req.wdata[1:0];
    // Set beats clear so an event in the clearing cycle survives
    s_next.status = (s_reg.status & ~st_clr) | st_set;
    // One wait cycle, then a single low cycle that completes the access
    if (s_reg.waitreq && (req.read || req.write))
    begin
      s_next.waitreq = 1'b0;
      s_next.rdata = read_mux(req.addr, s_reg);
    end
    else
      s_next.waitreq = 1'b1;
    // Interrupt level follows the new status so it stays aligned with it
    s_next.irq = |(s_next.status & s_next.mask);
  end

  // State register
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_reg <= '0;
      s_reg.ctrl <= GTMR_CTRL_RST;
      s_reg.count <= GTMR_COUNT_RST;
      s_reg.period <= GTMR_PERIOD_RST;
      s_reg.status <= GTMR_STATUS_RST;
      s_reg.mask <= GTMR_MASK_RST;
      s_reg.waitreq <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from flops
  assign avs_readdata_o = s_reg.rdata;
  assign avs_waitrequest_o = s_reg.waitreq;
  assign irq_o = s_reg.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Steps of an aligned count
  sequence SEQ_SYNC_SRC;
    mode == GTMR_MODE_SYNC_CNT && active && ps_tick;
  endsequence
  sequence SEQ_SYNC_HOLD;
    (mode == GTMR_MODE_SYNC_CNT && active) [*3];
  endsequence

  // Steps of a gated interval: open for a cycle, then closing
  sequence SEQ_GATE_OPEN;
    active && mode == GTMR_MODE_GATED && gate_level;
  endsequence
  sequence SEQ_GATE_SHUT;
    active && mode == GTMR_MODE_GATED && gate_fall;
  endsequence

  // A match that may reach the pin; a mask write in that cycle is left out
  sequence SEQ_MATCH_UNMASKED;
    match && s_reg.mask[GTMR_ST_MATCH_BIT] && !(wr_accept && req.addr == GTMR_OFS_MASK);
  endsequence

  // First step of a register access: a request while waitrequest is high
  sequence SEQ_BUS_ASK;
    s_reg.waitreq && (req.read || req.write);
  endsequence

  // Counting follows the selected source
  AST_COUNT_STEP: assert property ((cnt_tick && !match && !wr_count_try)
    |=> s_reg.count == $past(s_reg.count) + 16'h0001)
    else $error("count did not advance by one");
  AST_ASYNC_DIRECT: assert property ((mode == GTMR_MODE_ASYNC_CNT && active && ps_tick)
    |-> cnt_tick)
    else $error("async tick not counted at once");
  AST_SYNC_LATE: assert property ((SEQ_SYNC_SRC ##1 SEQ_SYNC_HOLD) |-> cnt_tick)
    else $error("aligned tick missing three cycles later");
  AST_SYNC_NOT_RAW: assert property ((mode == GTMR_MODE_SYNC_CNT && ps_tick && !sync_tick)
    |-> !cnt_tick)
    else $error("sync mode counted the raw tick");
  AST_TIMER_SRC: assert property ((active && mode == GTMR_MODE_TIMER)
    |-> ps_in == s_reg.fcy_en)
    else $error("timer mode not fed by instruction clock");
  AST_PIN_SRC: assert property ((active && s_reg.ctrl.src) |-> ps_in == pin_rise)
    else $error("counter mode not fed by pin");

  // Control bits and the mode they decode to
  AST_CTRL_BITS: assert property (wr_ctrl
    |=> s_reg.ctrl.src == $past(req.wdata[1])
      && s_reg.ctrl.sync == $past(req.wdata[2])
      && s_reg.ctrl.gate == $past(req.wdata[6]))
    else $error("control bits at wrong positions");
  AST_GATED: assert property ((mode == GTMR_MODE_GATED && !gate_level) |-> !ps_in)
    else $error("gated mode counted with gate low");
  AST_GATE_FLAG: assert property ((SEQ_GATE_OPEN ##1 SEQ_GATE_SHUT)
    |=> s_reg.status[GTMR_ST_GATE_BIT])
    else $error("closing gate did not raise its flag");
  AST_TIMER_BITS: assert property ((active && !s_reg.ctrl.src && !s_reg.ctrl.gate)
    |-> ps_in == s_reg.fcy_en)
    else $error("timer bits did not select the instruction clock");
  AST_ASYNC_BITS: assert property ((active && s_reg.ctrl.src && !s_reg.ctrl.sync
    && ps_tick) |-> cnt_tick)
    else $error("async bits did not count the tick at once");

  // Run enable, prescale and idle stop
  AST_STOPPED: assert property ((!s_reg.ctrl.run && !wr_count_try)
    |=> $stable(s_reg.count))
    else $error("count moved while stopped");
  AST_RUN_OFF: assert property (!s_reg.ctrl.run |-> !ps_tick && !cnt_tick)
    else $error("prescaler or counter ticked while stopped");
  AST_PS_PASS: assert property ((s_reg.ctrl.ps == 2'h0 && ps_in && !ps_clear) |-> ps_tick)
    else $error("undivided input did not tick");
  AST_IDLE: assert property ((idle_i && s_reg.ctrl.idle_stop) |-> !cnt_tick && !ps_in)
    else $error("timer ran during idle with stop set");

  // Count writes
  AST_WR_BLOCK: assert property ((wr_count_try && wr_blocked && !cnt_tick)
    |=> $stable(s_reg.count))
    else $error("count write not ignored in sync mode");
  AST_COUNT_WRITE: assert property ((wr_count_try && !wr_blocked)
    |=> s_reg.count == $past(req.wdata[15:0]))
    else $error("count write not taken");

  // Period match, status flags and interrupt
  AST_MATCH: assert property ((match && !(wr_count_try && !wr_blocked))
    |=> s_reg.count == 16'h0000 && s_reg.status[GTMR_ST_MATCH_BIT])
    else $error("period match did not clear and flag");
  AST_IRQ_MATCH: assert property (SEQ_MATCH_UNMASKED |=> irq_o)
    else $error("unmasked match did not raise the interrupt");
  AST_ST_STICKY: assert property ((s_reg.status[GTMR_ST_MATCH_BIT]
    && !st_clr[GTMR_ST_MATCH_BIT]) |=> s_reg.status[GTMR_ST_MATCH_BIT])
    else $error("match flag dropped without a clear");
  AST_ST_CLEAR: assert property ((st_clr[GTMR_ST_MATCH_BIT] && !match)
    |=> !s_reg.status[GTMR_ST_MATCH_BIT])
    else $error("match flag not cleared by a one");
  AST_IRQ: assert property (irq_o == |(s_reg.status & s_reg.mask))
    else $error("interrupt does not follow masked status");

  // Bus handshake: one low cycle per access, read data held between accesses
  AST_BUS_ANSWER: assert property (SEQ_BUS_ASK |=> !s_reg.waitreq)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!s_reg.waitreq |=> s_reg.waitreq)
    else $error("waitrequest low for more than one cycle");
  AST_RDATA_HOLD: assert property (!(s_reg.waitreq && (req.read || req.write))
    |=> $stable(avs_readdata_o))
    else $error("read data changed outside an access");

endmodule

// ===== bench/tb.sv
// Self-checking bench for the timer: register bus tasks and mode tests.
`timescale 1ns/1ps

module tb;
  import gtmr_pkg::*;

  localparam int unsigned DIV = GTMR_INSTR_DIV;

  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic external_count_input_i = 1'b0;
  logic gate_input_i = 1'b0;
  logic idle_i = 1'b0;
  logic irq_o;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;
  int t1;

  gtmr_timer #(.INSTR_DIV(DIV)) DUT (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .external_count_input_i(external_count_input_i),
    .gate_input_i(gate_input_i),
    .idle_i(idle_i),
    .irq_o(irq_o)
  );

  // Clock and a free cycle count used to time interrupt spacing
  initial
    forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %08h, expected %08h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One Avalon access; an edge passes first so strobes never rise twice in a step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    check(32'(n >= 20), 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  function automatic logic [31:0] ctl(input logic run, input logic idle, input logic gate,
                                      input logic [1:0] ps, input logic sync, input logic src);
    return {16'h0000, run, 1'b0, idle, 6'h00, gate, ps, 1'b0, sync, src, 1'b0};
  endfunction

  // Waits on the pre-edge level so both interrupt edges are timed alike
  task automatic wait_irq(input logic lvl, output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (irq_o !== lvl && n < 20000);
    t = cyc;
    check(32'(n >= 20000), 32'h0000_0000);
  endtask

  // Spacing of two period matches is phase free: (period + 1) ticks
  task automatic measure(input logic [31:0] c, input int exp);
    wr(GTMR_OFS_PERIOD, 32'h0000_0007);
    wr(GTMR_OFS_MASK, 32'h0000_0001);
    wr(GTMR_OFS_COUNT, 32'h0000_0000);
    wr(GTMR_OFS_CTRL, c);
    wait_irq(1'b1, t0);
    wr(GTMR_OFS_STATUS, 32'h0000_0001);
    wait_irq(1'b0, t1);
    wait_irq(1'b1, t1);
    check(32'(t1 - t0), 32'(exp));
    wr(GTMR_OFS_CTRL, 32'h0000_0000);
    wr(GTMR_OFS_STATUS, 32'h0000_0003);
  endtask

  // Pin pulses two clocks high, two low, well inside the synchroniser's reach
  task automatic pulses(input int n);
    repeat (n)
    begin
      external_count_input_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      external_count_input_i <= 1'b0;
      repeat (2) @(posedge clock_i);
    end
    repeat (10) @(posedge clock_i);
  endtask

  // Watchdog sized well above the longest prescale measurement
  initial
  begin
    repeat (40000) @(posedge clock_i);
    err_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    int divs[4];
    divs = '{1, 8, 64, 256};
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(GTMR_OFS_CTRL, 32'h0000_0000);
    rd(GTMR_OFS_COUNT, 32'h0000_0000);
    rd(GTMR_OFS_PERIOD, 32'h0000_FFFF);
    rd(GTMR_OFS_STATUS, 32'h0000_0000);
    rd(GTMR_OFS_MASK, 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    wr(GTMR_OFS_CTRL, 32'h0000_FFFF);
    rd(GTMR_OFS_CTRL, ctl(1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1));
    wr(GTMR_OFS_CTRL, 32'h0000_0000);
    $display("test registers finished, mismatches %0d", err_count);
    // Timer mode at every prescale; the sync bit is set to show it is ignored
    for (int p = 0; p < 4; p++)
      measure(ctl(1'b1, 1'b0, 1'b0, 2'(p), 1'b1, 1'b0), 8 * divs[p] * DIV);
    idle_i <= 1'b1;
    measure(ctl(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0), 8 * DIV);
    wr(GTMR_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
    wr(GTMR_OFS_COUNT, 32'h0000_0010);
    repeat (100) @(posedge clock_i);
    rd(GTMR_OFS_COUNT, 32'h0000_0010);
    idle_i <= 1'b0;
    wr(GTMR_OFS_CTRL, 32'h0000_0000);
    wr(GTMR_OFS_COUNT, 32'h0000_0055);
    repeat (100) @(posedge clock_i);
    rd(GTMR_OFS_COUNT, 32'h0000_0055);
    $display("test timer finished, mismatches %0d", err_count);
    // Gated timer: closed gate holds the count, falling gate raises a flag
    wr(GTMR_OFS_PERIOD, 32'h0000_FFFF);
    wr(GTMR_OFS_COUNT, 32'h0000_0000);
    wr(GTMR_OFS_CTRL, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
    repeat (50) @(posedge clock_i);
    rd(GTMR_OFS_COUNT, 32'h0000_0000);
    gate_input_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    gate_input_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rd(GTMR_OFS_STATUS, 32'h0000_0002);
    check(32'(irq_o), 32'h0000_0000);
    wr(GTMR_OFS_MASK, 32'h0000_0003);
    repeat (2) @(posedge clock_i);
    check(32'(irq_o), 32'h0000_0001);
    wr(GTMR_OFS_STATUS, 32'h0000_0002);
    repeat (3) @(posedge clock_i);
    check(32'(irq_o), 32'h0000_0000);
    $display("test gated finished, mismatches %0d", err_count);
    // Asynchronous then synchronous counter; gate bit set to show it is ignored
    for (int s = 0; s < 2; s++)
    begin
      wr(GTMR_OFS_CTRL, 32'h0000_0000);
      wr(GTMR_OFS_COUNT, 32'h0000_0000);
      wr(GTMR_OFS_CTRL, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'(s), 1'b1));
      pulses(5);
      rd(GTMR_OFS_COUNT, 32'h0000_0005);
      wr(GTMR_OFS_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h1, 1'(s), 1'b1));
      pulses(16);
      rd(GTMR_OFS_COUNT, 32'h0000_0007);
      wr(GTMR_OFS_COUNT, 32'h0000_1234);
      rd(GTMR_OFS_COUNT, (s == 1) ? 32'h0000_0007 : 32'h0000_1234);
    end
    wr(GTMR_OFS_CTRL, 32'h0000_0000);
    $display("test counters finished, mismatches %0d", err_count);
    complete_run();
  end

endmodule
